/* File: mod_timer_pkg.sv */
// constants, field layout and types of the modulo timer register block
// How it works
// R1 - overflow flag, bit 7, sets when count wraps from limit to zero
// R2 - flag clears on zero write only after a status read saw it set
// R3 - counter reset write or any limit write also clears the flag
// R4 - irq enable bit 6 drives interrupt while flag is set; reset clears it
// R5 - software clears the flag before setting the irq enable
// R6 - writing one to bit 5 zeroes the counter; bit reads zero
// R7 - halt bit 4 freezes the count; counting resumes from held value
// R8 - reset sets the halt bit
// R9 - unused status bits 3:0 and config bits 7:6 read zero
// R10 - source select bits 5:4 pick bus, fixed, external fall or rise
// R11 - changing source keeps the count
// R12 - reset selects bus clock; undefined codes fall back to bus clock
// R13 - divider bits 3:0 divide by two to the code, codes above eight by 256
// R14 - changing divider keeps the count
// R15 - reset clears divider to divide by one
// R16 - four 8-bit registers: status, clock config, count, limit
// R17 - limit zero free-runs; limit write zeroes count and flag; resets to zero
// R18 - count register is read-only live count, reset to zero
// R19 - overflow between flag read and zero write cancels the clear
// R20 - external input synchronised and edge detected before the divider
`default_nettype none
package mod_timer_pkg;
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h4;
  localparam logic [3:0] OFS_CURRENT_COUNT  = 4'h8;
  localparam logic [3:0] OFS_WRAP_LIMIT     = 4'hC;
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_IRQ_ENABLE    = 6;
  localparam int BIT_COUNTER_RESET = 5;
  localparam int BIT_COUNTER_HALT  = 4;
  localparam int SOURCE_LSB        = 4;
  localparam int DIVIDER_LSB       = 0;
  localparam logic       RST_HALT       = 1'b1;
  localparam logic       RST_IRQ_ENABLE = 1'b0;
  localparam logic [7:0] RST_COUNT      = 8'h00;
  localparam logic [7:0] RST_WRAP_LIMIT = 8'h00;
  localparam logic [3:0] RST_DIVIDER    = 4'h0;
  localparam logic [3:0] DIVIDER_MAX    = 4'h8;
  localparam logic [7:0] FREE_RUN_TOP   = 8'hFF;
  localparam logic [7:0] DIV_FULL_MASK  = 8'hFF;

  typedef enum logic [1:0] {
    SRC_BUS      = 2'b00,
    SRC_FIXED    = 2'b01,
    SRC_EXT_FALL = 2'b10,
    SRC_EXT_RISE = 2'b11
  } source_type;
  localparam source_type RST_SOURCE = SRC_BUS;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_type;

  typedef struct packed {
    source_type source;
    logic [3:0] divider;
  } clock_cfg_type;
endpackage : mod_timer_pkg
`default_nettype wire

/* File: modulo_timer_registers.sv */
// modulo timer: avalon-mm register slave, clock source select, prescaler and 8-bit counter
`timescale 1ns/1ps
`default_nettype none
module modulo_timer_registers
  import mod_timer_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic        fixedRateClock,
  input  wire logic        externalTimerInput,
  output var  logic        overflowIrq
);

  // prescale mask: tick when the low 'code' bits of the divider count are all ones
  function automatic logic [7:0] divMask(input logic [3:0] code);
    logic [7:0] m;
    m = DIV_FULL_MASK;
    if (code <= DIVIDER_MAX) begin
      m = 8'((9'h001 << code) - 9'h001);
    end
    return m;
  endfunction : divMask

  // register state
  bus_state_type busState;
  bus_state_type next_busState;
  logic          next_waitrequest;
  logic [31:0]   next_readdata;
  logic [3:0]    respAddr;
  logic [3:0]    next_respAddr;
  logic          overflowFlag;
  logic          next_overflowFlag;
  logic          clearArmed;
  logic          next_clearArmed;
  logic          irqEnable;
  logic          next_irqEnable;
  logic          counterHalt;
  logic          next_counterHalt;
  clock_cfg_type clockCfg;
  clock_cfg_type next_clockCfg;
  logic [7:0]    count;
  logic [7:0]    next_count;
  logic [7:0]    wrapLimit;
  logic [7:0]    next_wrapLimit;
  logic [7:0]    divCount;
  logic [7:0]    next_divCount;
  logic          next_overflowIrq;

  // pin synchronisers: stage 0 feeds stage 1 only
  logic [2:0]    fixSync;
  logic [2:0]    extSync;
  logic          fixLevel;
  logic          extLevel;
  logic          next_fixLevel;
  logic          next_extLevel;
  logic          fixRise;
  logic          extRise;
  logic          extFall;

  // decoded bus events and count events
  logic          accept;
  logic          wrEn;
  logic          rdStatus;
  logic          wrStatus;
  logic          wrConfig;
  logic          wrLimit;
  logic          ctrReset;
  logic          srcTick;
  logic          countTick;
  logic          overflow;
  logic [7:0]    topValue;
  logic [7:0]    wData;

  always_comb begin
    // an input edge counts only once the last two stages agree
    next_fixLevel = (fixSync[1] == fixSync[2]) ? fixSync[2] : fixLevel; // [R20]
    next_extLevel = (extSync[1] == extSync[2]) ? extSync[2] : extLevel; // [R20]
    fixRise = next_fixLevel & ~fixLevel;
    extRise = next_extLevel & ~extLevel; // [R20]
    extFall = ~next_extLevel & extLevel; // [R20]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fixSync  <= 3'b000;
      extSync  <= 3'b000;
      fixLevel <= 1'b0;
      extLevel <= 1'b0;
    end else begin
      fixSync  <= {fixSync[1:0], fixedRateClock};
      extSync  <= {extSync[1:0], externalTimerInput};
      fixLevel <= next_fixLevel;
      extLevel <= next_extLevel;
    end
  end

  always_comb begin
    // a request is taken once, in the cycle before waitrequest drops
    accept   = (read | write) & (busState == BUS_IDLE);
    wrEn     = accept & write & byteenable[0];
    wData    = writedata[7:0];
    rdStatus = accept & read & (address == OFS_STATUS_CONTROL);
    wrStatus = wrEn & (address == OFS_STATUS_CONTROL);
    wrConfig = wrEn & (address == OFS_CLOCK_CONFIG);
    wrLimit  = wrEn & (address == OFS_WRAP_LIMIT);
    ctrReset = (wrStatus & wData[BIT_COUNTER_RESET]) | wrLimit; // [R3] [R6] [R17]

    case (clockCfg.source) // [R10] [R11]
      SRC_BUS:      srcTick = 1'b1;
      SRC_FIXED:    srcTick = fixRise;
      SRC_EXT_FALL: srcTick = extFall;
      SRC_EXT_RISE: srcTick = extRise;
      default:      srcTick = 1'b1; // [R12]
    endcase

    // divider runs only while counting; a new divide code takes effect at once
    countTick = ~counterHalt & srcTick & // [R13] [R14]
                ((divCount & divMask(clockCfg.divider)) == divMask(clockCfg.divider));
    topValue  = (wrapLimit == 8'h00) ? FREE_RUN_TOP : wrapLimit; // [R17]
    overflow  = countTick & ~ctrReset & (count == topValue); // [R1]

    next_divCount = divCount;
    if (~counterHalt & srcTick) begin
      next_divCount = divCount + 8'h01;
    end

    next_count = count;
    if (ctrReset) begin
      next_count = RST_COUNT; // [R6] [R17]
    end else if (countTick) begin
      next_count = overflow ? RST_COUNT : count + 8'h01; // [R1] [R7] [R11] [R14]
    end

    next_irqEnable   = irqEnable;
    next_counterHalt = counterHalt;
    if (wrStatus) begin
      next_irqEnable   = wData[BIT_IRQ_ENABLE];
      next_counterHalt = wData[BIT_COUNTER_HALT]; // [R7]
    end
    next_clockCfg = clockCfg;
    if (wrConfig) begin
      next_clockCfg.source  = source_type'(wData[SOURCE_LSB +: 2]); // [R10]
      next_clockCfg.divider = wData[DIVIDER_LSB +: 4]; // [R13]
    end
    next_wrapLimit = wrLimit ? wData : wrapLimit; // [R17]

    // a status read arms the clear; a fresh overflow disarms it, so the set wins
    next_clearArmed = clearArmed;
    if (overflow | ctrReset | wrStatus) begin
      next_clearArmed = 1'b0; // [R19]
    end else if (rdStatus & overflowFlag) begin
      next_clearArmed = 1'b1; // [R2]
    end
    next_overflowFlag = overflowFlag;
    if (ctrReset) begin
      next_overflowFlag = 1'b0; // [R3]
    end else if (wrStatus & clearArmed & ~wData[BIT_OVERFLOW_FLAG]) begin
      next_overflowFlag = 1'b0; // [R2]
    end
    if (overflow) begin
      next_overflowFlag = 1'b1; // [R1] [R19]
    end
    next_overflowIrq = next_overflowFlag & next_irqEnable; // [R4]

    next_busState    = accept ? BUS_ANSWER : BUS_IDLE;
    next_waitrequest = ~accept;
    next_respAddr    = accept ? address : respAddr;
    next_readdata    = 32'h0000_0000;
    if (accept & read) begin
      case (address) // [R9] [R16]
        OFS_STATUS_CONTROL: next_readdata[7:0] = {overflowFlag, irqEnable, 1'b0,
                                                  counterHalt, 4'h0}; // [R6]
        OFS_CLOCK_CONFIG:   next_readdata[7:0] = {2'b00, clockCfg};
        OFS_CURRENT_COUNT:  next_readdata[7:0] = count; // [R18]
        OFS_WRAP_LIMIT:     next_readdata[7:0] = wrapLimit;
        default:            next_readdata      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busState     <= BUS_IDLE;
      waitrequest  <= 1'b1;
      readdata     <= 32'h0000_0000;
      respAddr     <= OFS_STATUS_CONTROL;
      overflowFlag <= 1'b0;
      clearArmed   <= 1'b0;
      irqEnable    <= RST_IRQ_ENABLE; // [R4]
      counterHalt  <= RST_HALT; // [R8]
      clockCfg     <= '{source: RST_SOURCE, divider: RST_DIVIDER}; // [R12] [R15]
      count        <= RST_COUNT; // [R18]
      wrapLimit    <= RST_WRAP_LIMIT; // [R17]
      divCount     <= 8'h00;
      overflowIrq  <= 1'b0;
    end else begin
      busState     <= next_busState;
      waitrequest  <= next_waitrequest;
      readdata     <= next_readdata;
      respAddr     <= next_respAddr;
      overflowFlag <= next_overflowFlag;
      clearArmed   <= next_clearArmed;
      irqEnable    <= next_irqEnable;
      counterHalt  <= next_counterHalt;
      clockCfg     <= next_clockCfg;
      count        <= next_count;
      wrapLimit    <= next_wrapLimit;
      divCount     <= next_divCount;
      overflowIrq  <= next_overflowIrq;
    end
  end

  property p_overflow_sets;
    @(posedge core_clk) disable iff (!rst_n)
      (countTick && !ctrReset && count == topValue) |=> (overflowFlag && count == 8'h00);
  endproperty
  a_overflow_sets: assert property (p_overflow_sets) else $error("wrap did not set flag"); // [R1]

  property p_two_step_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (wrStatus && clearArmed && !wData[7] && !overflow) |=> !overflowFlag;
  endproperty
  a_two_step_clear: assert property (p_two_step_clear) else $error("armed clear ignored"); // [R2]

  property p_clear_needs_read;
    @(posedge core_clk) disable iff (!rst_n)
      (overflowFlag && wrStatus && !clearArmed && !ctrReset) |=> overflowFlag;
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("bad clear"); // [R2] [R19]

  property p_counter_reset;
    @(posedge core_clk) disable iff (!rst_n)
      (wrStatus && wData[5] && !overflow) |=> (count == 8'h00 && !overflowFlag);
  endproperty
  a_counter_reset: assert property (p_counter_reset) else $error("reset bit failed"); // [R3] [R6]

  property p_irq_follows;
    @(posedge core_clk) disable iff (!rst_n)
      overflowIrq == (overflowFlag && irqEnable);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch"); // [R4]

  property p_halt_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (counterHalt && !ctrReset) |=> count == $past(count);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("count moved while halted"); // [R7]

  property p_reset_values;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> (counterHalt && !irqEnable && clockCfg == 6'h00 && count == 8'h00
                        && wrapLimit == 8'h00 && waitrequest);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset state"); // [R8] [R12] [R15]

  property p_unused_read_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (!waitrequest && respAddr == OFS_STATUS_CONTROL) |-> (readdata[5] == 1'b0
        && readdata[3:0] == 4'h0 && readdata[31:8] == 24'h00_0000);
  endproperty
  a_unused_read_zero: assert property (p_unused_read_zero) else $error("unused bits set"); // [R9]

  property p_limit_write;
    @(posedge core_clk) disable iff (!rst_n)
      wrLimit |=> (count == 8'h00 && !overflowFlag && wrapLimit == $past(wData));
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit write effect"); // [R17]

  property p_bus_runs;
    @(posedge core_clk) disable iff (!rst_n)
      (clockCfg.source == SRC_BUS && clockCfg.divider == 4'h0 && !counterHalt && !ctrReset
       && count != topValue) |=> count == $past(count) + 8'h01;
  endproperty
  a_bus_runs: assert property (p_bus_runs) else $error("no count at bus rate"); // [R10] [R13]

  // a second answer to one request would let the master take stale data
  property p_answer_one_cycle;
    @(posedge core_clk) disable iff (!rst_n)
      !waitrequest |=> waitrequest;
  endproperty
  a_answer_one_cycle: assert property (p_answer_one_cycle) else $error("long answer"); // [R16]

  property p_count_readonly;
    @(posedge core_clk) disable iff (!rst_n)
      (wrEn && address == OFS_CURRENT_COUNT && !countTick) |=> count == $past(count);
  endproperty
  a_count_readonly: assert property (p_count_readonly) else $error("count written"); // [R18]

  property p_config_keeps;
    @(posedge core_clk) disable iff (!rst_n)
      (wrConfig && !countTick) |=> count == $past(count);
  endproperty
  a_config_keeps: assert property (p_config_keeps) else $error("count cleared"); // [R11] [R14]

  property p_edge_counts;
    @(posedge core_clk) disable iff (!rst_n)
      (clockCfg.source == SRC_EXT_RISE && clockCfg.divider == 4'h0 && !counterHalt
       && extRise && !ctrReset && count != topValue) |=> count == $past(count) + 8'h01;
  endproperty
  a_edge_counts: assert property (p_edge_counts) else $error("edge missed"); // [R10] [R20]

endmodule : modulo_timer_registers
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the modulo timer register block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mod_timer_pkg::*;
;
  localparam logic [3:0] SC = OFS_STATUS_CONTROL;
  localparam logic [3:0] CK = OFS_CLOCK_CONFIG;
  localparam logic [3:0] CN = OFS_CURRENT_COUNT;
  localparam logic [3:0] LM = OFS_WRAP_LIMIT;
  logic        core_clk           = 1'b0;
  logic        rst_n              = 1'b0;
  logic [3:0]  address            = 4'h0;
  logic        read               = 1'b0;
  logic        write              = 1'b0;
  logic [31:0] writedata          = 32'h0000_0000;
  logic [3:0]  byteenable         = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        fixedRateClock     = 1'b0;
  logic        externalTimerInput = 1'b0;
  logic        overflowIrq;
  logic [31:0] q;
  logic [31:0] q1;
  logic [31:0] q2;
  int          errors             = 0;
  int          total_checks       = 0;
  int          cycles             = 0;
  int          seed               = 32'h59ee_7939;
  int          lim;
  int          n;

  modulo_timer_registers modulo_timer_registers_inst (
    .core_clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .fixedRateClock, .externalTimerInput, .overflowIrq
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // request held until waitrequest is sampled low; an extra edge keeps release and raise apart
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    address    <= a;
    writedata  <= {24'h00_0000, d};
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    r = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1, q);
  endtask : wr

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] e, input string what);
    bus(1'b0, a, 8'h00, 4'h1, q);
    check(what, q, {24'h00_0000, e});
  endtask : expect_reg

  // three cycles per level keeps each pulse above the synchroniser's minimum width
  task automatic pulse(input logic fixed, input int cnt);
    repeat (cnt) begin
      if (fixed) fixedRateClock <= 1'b1;
      else externalTimerInput <= 1'b1;
      repeat (3) @(posedge core_clk);
      fixedRateClock     <= 1'b0;
      externalTimerInput <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask : pulse

  function automatic logic [7:0] wrap_of(input int cnt, input int top);
    return 8'((top == 0) ? cnt % 256 : cnt % (top + 1));
  endfunction : wrap_of

  function automatic logic [7:0] flag_of(input int cnt, input int top);
    return (cnt > ((top == 0) ? 255 : top)) ? 8'h80 : 8'h00;
  endfunction : flag_of

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    expect_reg(SC, 8'h10, "status reset");
    expect_reg(CK, 8'h00, "config reset");
    expect_reg(CN, 8'h00, "count reset");
    expect_reg(LM, 8'h00, "limit reset");
    expect_reg(4'h2, 8'h00, "unmapped");
    wr(CK, 8'hFF);
    expect_reg(CK, 8'h3F, "config bits");
    wr(SC, 8'h1F);
    expect_reg(SC, 8'h10, "status bits");
    wr(CK, 8'h32);
    wr(SC, 8'h00);
    pulse(1'b0, 12);
    expect_reg(CN, 8'h03, "div4");
    wr(CK, 8'h30);
    expect_reg(CN, 8'h03, "div change");
    pulse(1'b0, 3);
    expect_reg(CN, 8'h06, "div1");
    wr(CK, 8'h20);
    expect_reg(CN, 8'h06, "src change");
    pulse(1'b0, 2);
    expect_reg(CN, 8'h08, "falling");
    wr(CK, 8'h10);
    pulse(1'b0, 2);
    pulse(1'b1, 3);
    expect_reg(CN, 8'h0B, "fixed");
    wr(CK, 8'h30);
    wr(SC, 8'h10);
    pulse(1'b0, 3);
    expect_reg(CN, 8'h0B, "halted");
    wr(SC, 8'h00);
    pulse(1'b0, 2);
    expect_reg(CN, 8'h0D, "resumed");
    wr(CK, 8'h00);
    bus(1'b0, CN, 8'h00, 4'h1, q1);
    bus(1'b0, CN, 8'h00, 4'h1, q2);
    // bus source counts every clock; the second read is taken three edges after the first
    check("bus source", q2, {24'h00_0000, q1[7:0] + 8'h03});
    wr(SC, 8'h30);
    expect_reg(CN, 8'h00, "counter reset");
    wr(CN, 8'h55);
    expect_reg(CN, 8'h00, "count write");
    wr(CK, 8'h30);
    wr(SC, 8'h00);
    repeat (5) begin
      lim = 1 + ($unsigned($random(seed)) % 12);
      n   = $unsigned($random(seed)) % 30;
      wr(LM, lim[7:0]);
      pulse(1'b0, n);
      expect_reg(CN, wrap_of(n, lim), "count");
      expect_reg(SC, flag_of(n, lim), "flag");
    end
    wr(LM, 8'h00);
    pulse(1'b0, 257);
    expect_reg(CN, wrap_of(257, 0), "free count");
    expect_reg(SC, flag_of(257, 0), "free flag");
    wr(LM, 8'h03);
    pulse(1'b0, 4);
    wr(SC, 8'h00);
    expect_reg(SC, 8'h80, "no read");
    wr(SC, 8'h00);
    expect_reg(SC, 8'h00, "cleared");
    pulse(1'b0, 4);
    expect_reg(SC, 8'h80, "set again");
    pulse(1'b0, 4);
    wr(SC, 8'h00);
    expect_reg(SC, 8'h80, "abandoned");
    wr(SC, 8'h00);
    wr(SC, 8'h40);
    check("irq idle", {24'h00_0000, 7'h00, overflowIrq}, 32'h0000_0000);
    pulse(1'b0, 4);
    check("irq set", {24'h00_0000, 7'h00, overflowIrq}, 32'h0000_0001);
    expect_reg(SC, 8'hC0, "irq status");
    wr(SC, 8'h40);
    check("irq clear", {24'h00_0000, 7'h00, overflowIrq}, 32'h0000_0000);
    wr(SC, 8'h00);
    pulse(1'b0, 6);
    wr(SC, 8'h20);
    expect_reg(SC, 8'h00, "reset bit flag");
    expect_reg(CN, 8'h00, "reset bit count");
    pulse(1'b0, 5);
    check("irq masked", {24'h00_0000, 7'h00, overflowIrq}, 32'h0000_0000);
    wr(LM, 8'h07);
    expect_reg(SC, 8'h00, "limit flag");
    expect_reg(CN, 8'h00, "limit count");
    bus(1'b1, LM, 8'h99, 4'h0, q);
    expect_reg(LM, 8'h07, "masked write");
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    expect_reg(LM, 8'h00, "limit rerun");
    expect_reg(SC, 8'h10, "status rerun");
    expect_reg(CK, 8'h00, "config rerun");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
